//--- hw/alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
  import mcu_exec_pkg::*;
  logic [DATA_W-1:0] acc_in;
  logic [DATA_W-1:0] opnd_in;
  alu_op_type op;
  logic carry_in;
  logic [DATA_W-1:0] result;
  logic carry_out;
  logic half_out;
  logic zero_out;
  modport core (output acc_in, opnd_in, op, carry_in,
                input result, carry_out, half_out, zero_out);
  modport unit (input acc_in, opnd_in, op, carry_in,
                output result, carry_out, half_out, zero_out);
endinterface
`default_nettype wire

//--- hw/alu_unit.sv
`timescale 1ns/1ps
`default_nettype none
module alu_unit
  import mcu_exec_pkg::*;
(
  // Operands and results
  alu_if.unit bus
);

  logic [DATA_W:0] diff;
  logic [NIB_W:0] half_diff;

  // ----------------------------------------------------------------
  // Subtraction as operand plus inverted accumulator plus one
  // ----------------------------------------------------------------
  // Carry out of the add is the inverse of borrow, as the flag wants
  assign diff = {1'b0, bus.opnd_in} + {1'b0, ~bus.acc_in}
              + {{DATA_W{1'b0}}, 1'b1};
  assign half_diff = {1'b0, bus.opnd_in[NIB_W-1:0]}
                   + {1'b0, ~bus.acc_in[NIB_W-1:0]}
                   + {{NIB_W{1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Result and flag selection
  // ----------------------------------------------------------------
  always_comb begin
    bus.result = bus.opnd_in;
    bus.carry_out = bus.carry_in;
    bus.half_out = 1'b0;
    case (bus.op)
      ALU_PASS: bus.result = bus.opnd_in;
      ALU_INC: bus.result = bus.opnd_in + {{(DATA_W-1){1'b0}}, 1'b1};
      ALU_OR: bus.result = bus.opnd_in | bus.acc_in;
      ALU_XOR: bus.result = bus.opnd_in ^ bus.acc_in;
      ALU_SUB: begin
        bus.result = diff[DATA_W-1:0];
        bus.carry_out = diff[DATA_W];
        bus.half_out = half_diff[NIB_W];
      end
      ALU_RLC: begin
        bus.result = {bus.opnd_in[DATA_W-2:0], bus.carry_in};
        bus.carry_out = bus.opnd_in[DATA_W-1];
      end
      ALU_RRC: begin
        bus.result = {bus.carry_in, bus.opnd_in[DATA_W-1:1]};
        bus.carry_out = bus.opnd_in[0];
      end
      ALU_SWAP: bus.result = {bus.opnd_in[NIB_W-1:0],
                              bus.opnd_in[DATA_W-1:NIB_W]};
      default: bus.result = bus.opnd_in;
    endcase
  end

  assign bus.zero_out = (bus.result == '0);

endmodule // alu_unit
`default_nettype wire

//--- hw/mcu_exec_pkg.sv
`default_nettype none
package mcu_exec_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int FADDR_FIELD_W = 7;
  localparam int RADDR_FIELD_W = 6;
  localparam int LIT_HI = 7;
  localparam int MISC_SEL_HI = 7;
  localparam int MISC_SEL_LO = 6;

  // ----------------------------------------------------------------
  // Opcode field values (bits 13..8)
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_MISC = 6'h00;
  localparam logic [5:0] OPC_SUB = 6'h02;
  localparam logic [5:0] OPC_IOR_F = 6'h04;
  localparam logic [5:0] OPC_XOR_F = 6'h06;
  localparam logic [5:0] OPC_MOVF = 6'h08;
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [5:0] OPC_RRC = 6'h0c;
  localparam logic [5:0] OPC_RLC = 6'h0d;
  localparam logic [5:0] OPC_SWAP = 6'h0e;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_RET_LIT = 6'h18;
  localparam logic [5:0] OPC_LOAD_LIT = 6'h19;
  localparam logic [5:0] OPC_IOR_L = 6'h1a;
  localparam logic [5:0] OPC_XOR_L = 6'h1f;
  localparam logic [1:0] MISC_RPLANE = 2'h0;

  // ----------------------------------------------------------------
  // Whole control words
  // ----------------------------------------------------------------
  localparam logic [13:0] WORD_NOP = 14'h0000;
  localparam logic [13:0] WORD_SLEEP = 14'h0003;
  localparam logic [13:0] WORD_WDT_CLR = 14'h0004;
  localparam logic [13:0] WORD_SUB_EXIT = 14'h0040;
  localparam logic [13:0] WORD_IRQ_EXIT = 14'h0060;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic WDT_FLAG_RST = 1'b1;
  localparam logic SLEEP_FLAG_RST = 1'b1;
  localparam logic IRQ_ALLOW_RST = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ALU_PASS = 3'h0,
    ALU_INC = 3'h1,
    ALU_OR = 3'h2,
    ALU_XOR = 3'h3,
    ALU_SUB = 3'h4,
    ALU_RLC = 3'h5,
    ALU_RRC = 3'h6,
    ALU_SWAP = 3'h7
  } alu_op_type;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_FLUSH = 2'b01,
    ST_STANDBY = 2'b11
  } exec_state_type;

endpackage
`default_nettype wire

//--- hw/mcu_instruction_execute.sv
// Notes on behaviour
// - Increment file, destination select, zero flag only
// - Increment, skip next when zero, no flags
// - OR literal into accumulator, zero flag
// - OR accumulator with file, chosen destination
// - Copy file register into accumulator
// - Load literal into accumulator, flags kept
// - Store accumulator into file, flags kept
// - Interrupt exit pops stack, allows interrupts
// - Literal exit loads accumulator, pops stack
// - Subroutine exit pops stack into counter
// - Rotate left through carry flag
// - Rotate right through carry flag
// - Sleep enters standby, updates power flags
// - Subtract accumulator from file, three flags
// - Swap file nibbles, flags kept
// - Zero test sets zero flag only
// - XOR literal into accumulator, zero flag
// - XOR accumulator with file, chosen destination
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute
  import mcu_exec_pkg::*;
#(
  parameter int PC_W = 10,
  parameter int FILE_ADDR_W = 7,
  parameter int RPLANE_ADDR_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction stream from program memory
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic nop_slot,
  // File register port
  output logic [FILE_ADDR_W-1:0] file_raddr,
  input wire logic [DATA_W-1:0] file_rdata,
  output logic file_we,
  output logic [FILE_ADDR_W-1:0] file_waddr,
  output logic [DATA_W-1:0] file_wdata,
  // Write-only register plane
  output logic rplane_we,
  output logic [RPLANE_ADDR_W-1:0] rplane_addr,
  output logic [DATA_W-1:0] rplane_wdata,
  // Return stack and program counter
  input wire logic [PC_W-1:0] stack_head,
  output logic stack_pop,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  // Interrupt control
  input wire logic irq_taken,
  output logic global_irq_allow,
  // Power control
  input wire logic wake_pin,
  output logic standby,
  // Core state
  output logic [DATA_W-1:0] acc_value,
  output logic carry_flag,
  output logic half_nibble_flag,
  output logic result_null_flag,
  output logic watchdog_expiry_flag,
  output logic sleep_entry_flag
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Address widths cannot exceed the instruction operand fields
  if (FILE_ADDR_W < 1 || FILE_ADDR_W > FADDR_FIELD_W) begin : g_bad_faddr
    $error("FILE_ADDR_W outside the operand field");
  end
  if (RPLANE_ADDR_W < 1 || RPLANE_ADDR_W > RADDR_FIELD_W) begin : g_bad_raddr
    $error("RPLANE_ADDR_W outside the operand field");
  end
  if (PC_W < 1) begin : g_bad_pc
    $error("PC_W must be positive");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  exec_state_type state_reg;
  exec_state_type state_next;
  logic [DATA_W-1:0] acc_reg;
  logic carry_reg;
  logic half_reg;
  logic zero_reg;
  logic wdt_flag_reg;
  logic sleep_flag_reg;
  logic irq_allow_reg;
  logic file_we_reg;
  logic [FILE_ADDR_W-1:0] file_waddr_reg;
  logic [DATA_W-1:0] file_wdata_reg;
  logic rplane_we_reg;
  logic [RPLANE_ADDR_W-1:0] rplane_addr_reg;
  logic [DATA_W-1:0] rplane_wdata_reg;
  logic stack_pop_reg;
  logic pc_load_reg;
  logic [PC_W-1:0] pc_value_reg;
  logic wake_s1_reg;
  logic wake_s2_reg;
  logic wake_s3_reg;
  logic wake_seen;

  logic [5:0] opc;
  logic dest_file;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] file_val;
  logic exec_now;

  // Decoded controls
  alu_op_type dec_op;
  logic dec_use_lit;
  logic dec_use_acc;
  logic dec_wr_acc;
  logic dec_wr_file;
  logic dec_upd_z;
  logic dec_upd_c;
  logic dec_upd_dc;
  logic dec_skip;
  logic dec_pop;
  logic dec_irq_exit;
  logic dec_sleep;
  logic dec_rplane;

  alu_if alu_bus ();

  // ----------------------------------------------------------------
  // Instruction fields and operand fetch
  // ----------------------------------------------------------------
  assign opc = instr_word[OPC_HI:OPC_LO];
  assign dest_file = instr_word[DEST_BIT];
  assign lit = instr_word[LIT_HI:0];
  assign file_raddr = instr_word[FILE_ADDR_W-1:0];
  assign exec_now = instr_valid && (state_reg == ST_EXEC);

  // The file write lands one cycle late, so a back-to-back read of
  // the same address takes the pending value instead of stale data
  assign file_val = (file_we_reg && file_waddr_reg == file_raddr)
                  ? file_wdata_reg : file_rdata;

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  always_comb begin
    dec_op = ALU_PASS;
    dec_use_lit = 1'b0;
    dec_use_acc = 1'b0;
    dec_wr_acc = 1'b0;
    dec_wr_file = 1'b0;
    dec_upd_z = 1'b0;
    dec_upd_c = 1'b0;
    dec_upd_dc = 1'b0;
    dec_skip = 1'b0;
    dec_pop = 1'b0;
    dec_irq_exit = 1'b0;
    dec_sleep = 1'b0;
    dec_rplane = 1'b0;
    case (opc)
      OPC_INC: begin
        dec_op = ALU_INC;
        dec_wr_acc = !dest_file;
        dec_wr_file = dest_file;
        dec_upd_z = 1'b1;
      end
      OPC_INC_SKIP: begin
        dec_op = ALU_INC;
        dec_wr_acc = !dest_file;
        dec_wr_file = dest_file;
        dec_skip = 1'b1;
      end
      OPC_IOR_L: begin
        dec_op = ALU_OR;
        dec_use_lit = 1'b1;
        dec_wr_acc = 1'b1;
        dec_upd_z = 1'b1;
      end
      OPC_IOR_F: begin
        dec_op = ALU_OR;
        dec_wr_acc = !dest_file;
        dec_wr_file = dest_file;
        dec_upd_z = 1'b1;
      end
      OPC_MOVF: begin
        // Bit 7 splits the plain copy from the zero test
        dec_wr_acc = !dest_file;
        dec_upd_z = dest_file;
      end
      OPC_LOAD_LIT: begin
        dec_use_lit = 1'b1;
        dec_wr_acc = 1'b1;
      end
      OPC_RET_LIT: begin
        dec_use_lit = 1'b1;
        dec_wr_acc = 1'b1;
        dec_pop = 1'b1;
      end
      OPC_RLC: begin
        dec_op = ALU_RLC;
        dec_wr_acc = !dest_file;
        dec_wr_file = dest_file;
        dec_upd_c = 1'b1;
      end
      OPC_RRC: begin
        dec_op = ALU_RRC;
        dec_wr_acc = !dest_file;
        dec_wr_file = dest_file;
        dec_upd_c = 1'b1;
      end
      OPC_SUB: begin
        dec_op = ALU_SUB;
        dec_wr_acc = !dest_file;
        dec_wr_file = dest_file;
        dec_upd_z = 1'b1;
        dec_upd_c = 1'b1;
        dec_upd_dc = 1'b1;
      end
      OPC_SWAP: begin
        dec_op = ALU_SWAP;
        dec_wr_acc = !dest_file;
        dec_wr_file = dest_file;
      end
      OPC_XOR_L: begin
        dec_op = ALU_XOR;
        dec_use_lit = 1'b1;
        dec_wr_acc = 1'b1;
        dec_upd_z = 1'b1;
      end
      OPC_XOR_F: begin
        dec_op = ALU_XOR;
        dec_wr_acc = !dest_file;
        dec_wr_file = dest_file;
        dec_upd_z = 1'b1;
      end
      OPC_MISC: begin
        if (dest_file) begin
          dec_use_acc = 1'b1;
          dec_wr_file = 1'b1;
        end else if (instr_word == WORD_SUB_EXIT) begin
          dec_pop = 1'b1;
        end else if (instr_word == WORD_IRQ_EXIT) begin
          dec_pop = 1'b1;
          dec_irq_exit = 1'b1;
        end else if (instr_word == WORD_SLEEP) begin
          dec_sleep = 1'b1;
        end else if (instr_word == WORD_NOP
                     || instr_word == WORD_WDT_CLR) begin
          dec_rplane = 1'b0;
        end else if (instr_word[MISC_SEL_HI:MISC_SEL_LO] == MISC_RPLANE) begin
          dec_rplane = 1'b1;
        end
      end
      default: dec_rplane = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Arithmetic unit
  // ----------------------------------------------------------------
  assign alu_bus.acc_in = acc_reg;
  assign alu_bus.opnd_in = dec_use_lit ? lit
                         : (dec_use_acc ? acc_reg : file_val);
  assign alu_bus.op = dec_op;
  assign alu_bus.carry_in = carry_reg;

  alu_unit u_alu (
    .bus (alu_bus.unit)
  );

  // ----------------------------------------------------------------
  // Wake pin synchroniser
  // ----------------------------------------------------------------
  // Only the second and third stages are looked at; the first may be
  // metastable
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_pin;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
    end
  end

  assign wake_seen = wake_s2_reg && wake_s3_reg;

  // ----------------------------------------------------------------
  // Sequencing: execute, discarded slot, standby
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_EXEC: begin
        if (exec_now && dec_sleep) begin
          state_next = ST_STANDBY;
        end else if (exec_now && (dec_pop
                     || (dec_skip && alu_bus.zero_out))) begin
          state_next = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        // The fetched word is dropped; this is the second cycle
        if (instr_valid) begin
          state_next = ST_EXEC;
        end
      end
      ST_STANDBY: begin
        if (wake_seen) begin
          state_next = ST_EXEC;
        end
      end
      default: state_next = ST_EXEC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_reg <= ACC_RST;
    end else if (exec_now && dec_wr_acc) begin
      acc_reg <= alu_bus.result;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      carry_reg <= FLAG_RST;
      half_reg <= FLAG_RST;
      zero_reg <= FLAG_RST;
    end else if (exec_now) begin
      if (dec_upd_c) begin
        carry_reg <= alu_bus.carry_out;
      end
      if (dec_upd_dc) begin
        half_reg <= alu_bus.half_out;
      end
      if (dec_upd_z) begin
        zero_reg <= alu_bus.zero_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power and interrupt flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      wdt_flag_reg <= WDT_FLAG_RST;
      sleep_flag_reg <= SLEEP_FLAG_RST;
    end else if (exec_now && dec_sleep) begin
      wdt_flag_reg <= 1'b1;
      sleep_flag_reg <= 1'b0;
    end
  end

  // An exit landing in the same cycle as an accepted interrupt wins,
  // so the allow bit is never lost on the way out
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_allow_reg <= IRQ_ALLOW_RST;
    end else if (exec_now && dec_irq_exit) begin
      irq_allow_reg <= 1'b1;
    end else if (irq_taken) begin
      irq_allow_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // File register write
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      file_we_reg <= 1'b0;
      file_waddr_reg <= '0;
      file_wdata_reg <= '0;
    end else begin
      file_we_reg <= exec_now && dec_wr_file;
      if (exec_now && dec_wr_file) begin
        file_waddr_reg <= file_raddr;
        file_wdata_reg <= alu_bus.result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register plane write
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rplane_we_reg <= 1'b0;
      rplane_addr_reg <= '0;
      rplane_wdata_reg <= '0;
    end else begin
      rplane_we_reg <= exec_now && dec_rplane;
      if (exec_now && dec_rplane) begin
        rplane_addr_reg <= instr_word[RPLANE_ADDR_W-1:0];
        rplane_wdata_reg <= acc_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Return stack pop and counter load
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      stack_pop_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      pc_value_reg <= '0;
    end else begin
      stack_pop_reg <= exec_now && dec_pop;
      pc_load_reg <= exec_now && dec_pop;
      if (exec_now && dec_pop) begin
        pc_value_reg <= stack_head;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Standby refuses fetches; the flush slot still takes one to drop
  assign instr_ready = (state_reg != ST_STANDBY);
  assign nop_slot = (state_reg == ST_FLUSH);
  assign standby = (state_reg == ST_STANDBY);
  assign file_we = file_we_reg;
  assign file_waddr = file_waddr_reg;
  assign file_wdata = file_wdata_reg;
  assign rplane_we = rplane_we_reg;
  assign rplane_addr = rplane_addr_reg;
  assign rplane_wdata = rplane_wdata_reg;
  assign stack_pop = stack_pop_reg;
  assign pc_load = pc_load_reg;
  assign pc_value = pc_value_reg;
  assign global_irq_allow = irq_allow_reg;
  assign acc_value = acc_reg;
  assign carry_flag = carry_reg;
  assign half_nibble_flag = half_reg;
  assign result_null_flag = zero_reg;
  assign watchdog_expiry_flag = wdt_flag_reg;
  assign sleep_entry_flag = sleep_flag_reg;

endmodule // mcu_instruction_execute
`default_nettype wire

//--- tb/exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module exec_chk
  import mcu_exec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction stream
  input wire logic [13:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic nop_slot,
  // Outputs under watch
  input wire logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic global_irq_allow,
  input wire logic standby,
  input wire logic [7:0] acc_value,
  input wire logic carry_flag,
  input wire logic result_null_flag,
  input wire logic sleep_entry_flag
);
  // ----
  // Executed word and its opcode
  // ----
  wire ex = instr_valid && instr_ready && !nop_slot;
  wire [5:0] op = instr_word[13:8];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RET: assert property (ex && instr_word == WORD_SUB_EXIT |=>
    stack_pop && pc_load && nop_slot) else $error("return not popped");
  AST_IRQ_EXIT: assert property (ex && instr_word == WORD_IRQ_EXIT
    |-> ##[1:2] global_irq_allow) else $error("irq allow not set");
  AST_LIT: assert property (ex && op == OPC_LOAD_LIT |=>
    acc_value == $past(instr_word[7:0])) else $error("literal load");
  AST_STORE: assert property (ex && instr_word[13:7] == 7'h01 |=>
    file_we && file_wdata == $past(acc_value)
    && file_waddr == $past(instr_word[6:0])) else $error("store");
  AST_NULLT: assert property (ex && op == OPC_MOVF && instr_word[7]
    |=> result_null_flag == ($past(file_rdata) == 8'h00) && !file_we)
    else $error("zero test");
  AST_SWAP: assert property (ex && op == OPC_SWAP && !instr_word[7]
    |=> acc_value == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
    && $stable(carry_flag)) else $error("nibble swap");
  AST_SLEEP: assert property (ex && instr_word == WORD_SLEEP |=>
    standby && !instr_ready && !sleep_entry_flag) else $error("sleep");
  AST_SKIP: assert property (ex && op == OPC_INC_SKIP
    && file_rdata == 8'hff |=> nop_slot && $stable(result_null_flag))
    else $error("skip on zero");
  AST_DROP: assert property (nop_slot && instr_valid |=>
    !file_we && !stack_pop && $stable(acc_value)) else $error("drop");
  // Main scenarios reached
  cover property (ex && instr_word == WORD_SLEEP);
  cover property (stack_pop);
  cover property (nop_slot && instr_valid);
endmodule // exec_chk
bind mcu_instruction_execute exec_chk chk_u (.*);
`default_nettype wire

//--- tb/file_stack_model.sv
`timescale 1ns/1ps
`default_nettype none
module file_stack_model (
  // Clock
  input wire logic clk,
  // File port
  input wire logic [6:0] file_raddr,
  output logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  // Return stack
  input wire logic stack_pop,
  output logic [9:0] stack_head
);
  logic [7:0] mem [128];
  logic [9:0] stk [4];
  logic [1:0] sp = 2'h0;
  // Each cell starts at twice its address
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 2);
    stk = '{10'h123, 10'h2a5, 10'h0f0, 10'h3c3};
  end
  // Pending write is forwarded so a back-to-back read sees it
  assign file_rdata = (file_we && file_waddr == file_raddr) ?
    file_wdata : mem[file_raddr];
  assign stack_head = stk[sp];
  // Writes and pops land at the edge that ends their pulse
  always @(posedge clk) begin
    if (file_we) mem[file_waddr] <= file_wdata;
    if (stack_pop) sp <= sp + 2'h1;
  end
endmodule // file_stack_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mcu_exec_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, irq_taken = 1'b0;
  logic wake_pin = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] file_rdata, file_wdata, acc_value, rplane_wdata;
  logic [9:0] stack_head, pc_value;
  logic [6:0] file_raddr, file_waddr;
  logic [5:0] rplane_addr;
  logic instr_ready, nop_slot, file_we, rplane_we, stack_pop, pc_load;
  logic global_irq_allow, standby, carry_flag, half_nibble_flag;
  logic result_null_flag, watchdog_expiry_flag, sleep_entry_flag;
  int mismatches = 0, n_compared = 0;
  mcu_instruction_execute dut_u (.*);
  file_stack_model mem_u (.*);
  // ----
  // Helpers
  // ----
  always #2.5 clk = ~clk;
  // Wide enough for the longest packed compare (19 bits)
  task chk(input logic [23:0] g, input logic [23:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_sim;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One word offered for a single edge; outputs read just after it
  task run(input logic [13:0] w);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task lit(input logic [7:0] k);
    run({OPC_LOAD_LIT, k});
  endtask
  // ----
  // Scenarios
  // ----
  task t_skip;
    lit(8'hff);
    run({7'h01, 7'h10});
    chk({file_we, file_waddr, file_wdata}, {1'b1, 7'h10, 8'hff});
    run({OPC_INC_SKIP, 1'b0, 7'h10});
    chk({acc_value, nop_slot, result_null_flag}, 10'h002);
    lit(8'h33);
    chk(acc_value, 8'h00);
    run({OPC_INC, 1'b1, 7'h10});
    chk({file_we, file_wdata, result_null_flag}, 10'h201);
  endtask
  task t_lit;
    lit(8'h5a);
    chk(acc_value, 8'h5a);
    run({OPC_IOR_L, 8'h81});
    chk({acc_value, result_null_flag}, {8'hdb, 1'b0});
    run({OPC_XOR_L, 8'hdb});
    chk({acc_value, result_null_flag}, {8'h00, 1'b1});
  endtask
  task t_alu;
    lit(8'h0f);
    run({OPC_IOR_F, 1'b1, 7'h20});
    chk({file_we, file_wdata, result_null_flag}, 10'h29e);
    run({OPC_XOR_F, 1'b0, 7'h21});
    chk(acc_value, 8'h4d);
    run({OPC_MOVF, 1'b0, 7'h22});
    chk(acc_value, 8'h44);
    run({OPC_SUB, 1'b0, 7'h21});
    chk({acc_value, carry_flag, half_nibble_flag}, 10'h3f8);
    lit(8'h46);
    run({OPC_SUB, 1'b1, 7'h23});
    chk({file_wdata, carry_flag, half_nibble_flag, result_null_flag},
      11'h007);
    run({OPC_RLC, 1'b0, 7'h41});
    chk({acc_value, carry_flag}, {8'h05, 1'b1});
    run({OPC_RRC, 1'b0, 7'h40});
    chk({acc_value, carry_flag}, {8'hc0, 1'b0});
    run({OPC_SWAP, 1'b0, 7'h12});
    chk({acc_value, carry_flag, result_null_flag}, 10'h109);
    run({OPC_MOVF, 1'b1, 7'h01});
    chk({file_we, result_null_flag}, 2'b00);
    run({OPC_MOVF, 1'b1, 7'h00});
    chk({file_we, result_null_flag}, 2'b01);
  endtask
  task t_ret;
    run(WORD_SUB_EXIT);
    chk({stack_pop, pc_load, nop_slot, pc_value}, 13'h1d23);
    lit(8'h99);
    chk(acc_value, 8'h42);
    run({OPC_RET_LIT, 8'h77});
    chk({stack_pop, acc_value, pc_value}, 19'h5dea5);
    run(WORD_NOP);
    run(WORD_IRQ_EXIT);
    chk({stack_pop, pc_value}, 11'h4f0);
    run(WORD_NOP);
    chk(global_irq_allow, 1'b1);
    @(posedge clk);
    irq_taken <= 1'b1;
    @(posedge clk);
    irq_taken <= 1'b0;
    #1;
    chk(global_irq_allow, 1'b0);
  endtask
  task t_misc;
    run(14'h0005);
    chk({rplane_we, rplane_addr, rplane_wdata}, 15'h4577);
    run(14'h2000);
    chk({file_we, stack_pop, pc_load, nop_slot, acc_value}, 12'h077);
    run(WORD_WDT_CLR);
    chk({rplane_we, file_we, nop_slot, acc_value}, 11'h077);
    run({OPC_INC_SKIP, 1'b1, 7'h02});
    chk({file_we, file_wdata, nop_slot}, 10'h20a);
  endtask
  task t_sleep;
    int n;
    chk({standby, sleep_entry_flag}, 2'b01);
    run(WORD_SLEEP);
    chk({standby, instr_ready, watchdog_expiry_flag, sleep_entry_flag},
      4'b1010);
    @(posedge clk);
    wake_pin <= 1'b1;
    for (n = 0; n < 12 && standby !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    wake_pin <= 1'b0;
    if (n == 12) begin
      mismatches++;
      end_sim;
    end
    lit(8'h21);
    chk(acc_value, 8'h21);
  endtask
  // Reset for four cycles, then the scenarios in order
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_skip;
    t_lit;
    t_alu;
    t_ret;
    t_misc;
    t_sleep;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
